/* File: acrb_bank.v */
// Purpose: Shadowed configuration register bank of a dual-core 8-bit converter.
// Assumes: A serial engine outside presents decoded one-cycle write and read strobes.
// Notes:   Local registers are duplicated per channel and steered by the index register.
`timescale 1ns/10ps
`default_nettype none
`include "acrb_consts.vh"

module acrb_bank #(
  parameter DW = 8
) (
  // Clock and reset.
  input  wire          sys_clk,
  input  wire          rst_n,
  // Register access from the serial engine.
  input  wire          wr_en,
  input  wire          rd_en,
  input  wire [7:0]    addr,
  input  wire [7:0]    wdata,
  output reg  [7:0]    rdata_q,
  // Self-test signature inputs from each channel.
  input  wire [15:0]   sig_ch1,
  input  wire [15:0]   sig_ch2,
  input  wire          sig_load,
  // Raw converter data per channel, offset binary.
  input  wire [DW-1:0] raw_ch1,
  input  wire [DW-1:0] raw_ch2,
  // Active configuration and data outputs.
  output wire          power_down,
  output wire          simultaneous,
  output wire          clock_boost,
  output wire          duty_stab,
  output wire          cm_input_en,
  output wire          dco_invert,
  output wire [4:0]    ref_scale,
  output wire [1:0]    disconnect,
  output wire [1:0]    selftest_en,
  output wire [1:0]    selftest_init,
  output wire [7:0]    fine_skew,
  output wire [7:0]    coarse_skew,
  output wire [1:0]    out_en,
  output reg  [DW-1:0] dout_ch1_q,
  output reg  [DW-1:0] dout_ch2_q
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Offset binary to the selected format, then optional inversion.
  function [DW-1:0] fmt_conv;
    input [DW-1:0] d;
    input [1:0]    f;
    input          inv;
    reg   [DW-1:0] t;
    begin
      t = d;
      if (f == `ACRB_FMT_TWOS) begin
        t = {~d[DW-1], d[DW-2:0]};
      end else if (f == `ACRB_FMT_GRAY) begin
        t = d ^ (d >> 1);
      end
      fmt_conv = inv ? ~t : t;
    end
  endfunction

  // Test pattern for a code; PN patterns come from a shared LFSR.
  function [DW-1:0] tpat;
    input [2:0]    m;
    input          ph;
    input [22:0]   lf;
    begin
      case (m)
        `ACRB_TM_MID:    tpat = {1'b1, {(DW-1){1'b0}}};
        `ACRB_TM_PFS:    tpat = {DW{1'b1}};
        `ACRB_TM_NFS:    tpat = {DW{1'b0}};
        `ACRB_TM_CHECK:  tpat = ph ? {(DW/2){2'b10}} : {(DW/2){2'b01}};
        `ACRB_TM_PN23:   tpat = lf[DW-1:0];
        `ACRB_TM_PN9:    tpat = lf[DW+8:9];
        `ACRB_TM_TOGGLE: tpat = {DW{ph}};
        default:         tpat = {DW{1'b0}};
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Master (written) and slave (active) registers
  // ---------------------------------------------------------------
  reg [7:0]  index_q, xfer_q;
  reg [7:0]  m_power_q, m_clock_q, m_input_q, m_phase_q, m_ref_q, m_coarse_q;
  reg [7:0]  m_test_q [0:1];
  reg [7:0]  m_st_q   [0:1];
  reg [7:0]  m_off_q  [0:1];
  reg [7:0]  m_fmt_q  [0:1];
  reg [7:0]  m_fine_q [0:1];
  reg [7:0]  m_disc_q [0:1];
  reg [7:0]  s_power_q, s_clock_q, s_input_q, s_phase_q, s_ref_q, s_coarse_q;
  reg [7:0]  s_test_q [0:1];
  reg [7:0]  s_st_q   [0:1];
  reg [7:0]  s_off_q  [0:1];
  reg [7:0]  s_fmt_q  [0:1];
  reg [7:0]  s_fine_q [0:1];
  reg [7:0]  s_disc_q [0:1];
  reg [15:0] sig_q    [0:1];
  reg [22:0] lfsr_q;
  reg        ph_q;
  integer    i;

  wire xfer_go = wr_en && (addr == `ACRB_A_XFER) && (wdata == `ACRB_XFER_CMD);

  // Host writes land in master copies only, except index writes, which go straight to index_q; a local write goes to each selected channel.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      index_q    <= `ACRB_R_INDEX;
      m_power_q  <= `ACRB_R_POWER;
      m_clock_q  <= `ACRB_R_CLOCK;
      m_input_q  <= `ACRB_R_INPUT;
      m_phase_q  <= `ACRB_R_OUTPHASE;
      m_ref_q    <= `ACRB_R_REFSCALE;
      m_coarse_q <= `ACRB_R_COARSE;
      for (i = 0; i < 2; i = i + 1) begin
        m_test_q[i] <= `ACRB_R_TEST;
        m_st_q[i]   <= `ACRB_R_SELFTEST;
        m_off_q[i]  <= `ACRB_R_OFFSET;
        m_fmt_q[i]  <= `ACRB_R_OUTFMT;
        m_fine_q[i] <= `ACRB_R_FINE;
        m_disc_q[i] <= `ACRB_R_INPUT;
      end
    end else if (wr_en) begin
      if (addr == `ACRB_A_INDEX) begin
        index_q <= wdata;
      end else if (addr == `ACRB_A_POWER) begin
        m_power_q <= wdata;
      end else if (addr == `ACRB_A_CLOCK) begin
        m_clock_q <= wdata;
      end else if (addr == `ACRB_A_INPUT) begin
        m_input_q <= wdata;
      end else if (addr == `ACRB_A_OUTPHASE) begin
        m_phase_q <= wdata;
      end else if (addr == `ACRB_A_REFSCALE) begin
        m_ref_q <= wdata;                                  // [R5]
      end else if (addr == `ACRB_A_COARSE) begin
        m_coarse_q <= wdata;
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (index_q[i]) begin                              // [R11]
          if (addr == `ACRB_A_TEST) m_test_q[i] <= wdata;
          if (addr == `ACRB_A_SELFTEST) m_st_q[i] <= wdata;
          if (addr == `ACRB_A_OFFSET) m_off_q[i] <= wdata;
          if (addr == `ACRB_A_OUTFMT) m_fmt_q[i] <= wdata;
          if (addr == `ACRB_A_FINE) m_fine_q[i] <= wdata;
          if (addr == `ACRB_A_INPUT) m_disc_q[i] <= wdata;
        end
      end
    end
  end

  // Transfer: all slaves copy their masters in the same edge; the bit then reads clear.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      xfer_q     <= `ACRB_R_XFER;
      s_power_q  <= `ACRB_R_POWER;
      s_clock_q  <= `ACRB_R_CLOCK;
      s_input_q  <= `ACRB_R_INPUT;
      s_phase_q  <= `ACRB_R_OUTPHASE;
      s_ref_q    <= `ACRB_R_REFSCALE;
      s_coarse_q <= `ACRB_R_COARSE;
      for (i = 0; i < 2; i = i + 1) begin
        s_test_q[i] <= `ACRB_R_TEST;
        s_st_q[i]   <= `ACRB_R_SELFTEST;
        s_off_q[i]  <= `ACRB_R_OFFSET;
        s_fmt_q[i]  <= `ACRB_R_OUTFMT;
        s_fine_q[i] <= `ACRB_R_FINE;
        s_disc_q[i] <= `ACRB_R_INPUT;
      end
    end else if (xfer_go) begin                            // [R9]
      xfer_q     <= `ACRB_XFER_IDLE;                       // [R10]
      s_power_q  <= m_power_q;
      s_clock_q  <= m_clock_q;
      s_input_q  <= m_input_q;
      s_phase_q  <= m_phase_q;
      s_ref_q    <= m_ref_q;
      s_coarse_q <= m_coarse_q;
      for (i = 0; i < 2; i = i + 1) begin
        s_test_q[i] <= m_test_q[i];
        s_st_q[i]   <= m_st_q[i];
        s_off_q[i]  <= m_off_q[i];
        s_fmt_q[i]  <= m_fmt_q[i];
        s_fine_q[i] <= m_fine_q[i];
        s_disc_q[i] <= m_disc_q[i];
      end
    end else if (wr_en && addr == `ACRB_A_XFER) begin
      xfer_q <= `ACRB_XFER_IDLE;                           // [R10]
    end
  end

  // Signatures are loaded only by the self-test logic, never by host writes.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sig_q[0] <= 16'h0000;                                // [R6] [R7]
      sig_q[1] <= 16'h0000;
    end else if (sig_load) begin
      sig_q[0] <= sig_ch1;
      sig_q[1] <= sig_ch2;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Channel one wins whenever its select bit is set, covering the both-set case.
  wire       rc = index_q[0] ? 1'b0 : (index_q[1] ? 1'b1 : 1'b0);   // [R11]
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_en) begin
      if (addr == `ACRB_A_INDEX) rdata_q <= index_q;
      else if (addr == `ACRB_A_XFER) rdata_q <= xfer_q;
      else if (addr == `ACRB_A_POWER) rdata_q <= m_power_q;
      else if (addr == `ACRB_A_CLOCK) rdata_q <= m_clock_q;
      else if (addr == `ACRB_A_TEST) rdata_q <= m_test_q[rc];
      else if (addr == `ACRB_A_SELFTEST) rdata_q <= m_st_q[rc];
      else if (addr == `ACRB_A_INPUT)
        rdata_q <= {5'h00, m_disc_q[rc][`ACRB_B_DISC], m_input_q[`ACRB_B_CMEN], 1'b0};
      else if (addr == `ACRB_A_OFFSET) rdata_q <= m_off_q[rc];
      else if (addr == `ACRB_A_OUTFMT) rdata_q <= m_fmt_q[rc];
      else if (addr == `ACRB_A_OUTPHASE) rdata_q <= m_phase_q;
      else if (addr == `ACRB_A_REFSCALE) rdata_q <= m_ref_q;
      else if (addr == `ACRB_A_SIG_LO) rdata_q <= sig_q[rc][7:0];     // [R6]
      else if (addr == `ACRB_A_SIG_HI) rdata_q <= sig_q[rc][15:8];    // [R7]
      else if (addr == `ACRB_A_FINE) rdata_q <= m_fine_q[rc];
      else if (addr == `ACRB_A_COARSE) rdata_q <= m_coarse_q;
      else rdata_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Active controls
  // ---------------------------------------------------------------
  assign power_down    = (s_power_q[1:0] == `ACRB_PD_FULL);            // [R12]
  assign simultaneous  = s_clock_q[`ACRB_B_SMODE];                     // [R1]
  assign clock_boost   = s_clock_q[`ACRB_B_BOOST];
  assign duty_stab     = s_clock_q[`ACRB_B_DCS];
  assign cm_input_en   = s_input_q[`ACRB_B_CMEN];
  assign dco_invert    = s_phase_q[`ACRB_B_DCOINV];
  assign ref_scale     = s_ref_q[4:0];                                 // [R5]
  assign disconnect    = {s_disc_q[1][`ACRB_B_DISC], s_disc_q[0][`ACRB_B_DISC]};
  assign selftest_en   = {s_st_q[1][`ACRB_B_STEN], s_st_q[0][`ACRB_B_STEN]};
  assign selftest_init = {s_st_q[1][`ACRB_B_STINIT], s_st_q[0][`ACRB_B_STINIT]};
  assign fine_skew     = {s_fine_q[1][3:0], s_fine_q[0][3:0]};         // [R8]
  assign coarse_skew   = s_coarse_q;
  assign out_en        = {s_fmt_q[1][`ACRB_B_OUTEN], s_fmt_q[0][`ACRB_B_OUTEN]};  // [R3]

  // ---------------------------------------------------------------
  // Output data path
  // ---------------------------------------------------------------

  // Offset trim saturates instead of wrapping, so full-scale codes never flip.
  function [DW-1:0] trim;
    input [DW-1:0] d;
    input [3:0]    o;
    reg   [DW+1:0] s;
    begin
      s = {2'b00, d} + {{(DW-2){o[3]}}, o};
      if (s[DW+1]) trim = {DW{1'b0}};
      else if (s[DW]) trim = {DW{1'b1}};
      else trim = s[DW-1:0];
    end
  endfunction

  // Shared pattern sources; one LFSR keeps the area small at the cost of correlated PN data.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      lfsr_q <= 23'h7FFFFF;
      ph_q   <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[21:0], lfsr_q[22] ^ lfsr_q[17]};
      ph_q   <= ~ph_q;
    end
  end

  // Registered data outputs: test pattern, or trimmed and formatted data; zero when disabled.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dout_ch1_q <= {DW{1'b0}};
      dout_ch2_q <= {DW{1'b0}};
    end else begin
      if (!out_en[0]) dout_ch1_q <= {DW{1'b0}};                                  // [R3]
      else if (s_test_q[0][2:0] != `ACRB_TM_OFF)
        dout_ch1_q <= tpat(s_test_q[0][2:0], ph_q, lfsr_q);                      // [R13]
      else dout_ch1_q <= fmt_conv(trim(raw_ch1, s_off_q[0][3:0]),                // [R2]
                                  s_fmt_q[0][1:0], s_fmt_q[0][`ACRB_B_INVERT]);  // [R4]
      if (!out_en[1]) dout_ch2_q <= {DW{1'b0}};                                  // [R3]
      else if (s_test_q[1][2:0] != `ACRB_TM_OFF)
        dout_ch2_q <= tpat(s_test_q[1][2:0], ph_q, lfsr_q);                      // [R13]
      else dout_ch2_q <= fmt_conv(trim(raw_ch2, s_off_q[1][3:0]),                // [R2]
                                  s_fmt_q[1][1:0], s_fmt_q[1][`ACRB_B_INVERT]);  // [R4]
    end
  end

endmodule // acrb_bank
`default_nettype wire

/* File: acrb_consts.vh */
// Function
// R1 - Global sample-mode bit: 0 interleaves the two cores, 1 samples both simultaneously.
// R2 - Per-channel 4-bit two's complement offset trim, +7 down to -8 codes.
// R3 - Per-channel output enable and separate output data invert controls.
// R4 - Per-channel 2-bit format: offset binary, two's complement, Gray, 11 reserved.
// R5 - Global reference scaling field setting full-scale range, default zero.
// R6 - Per-channel signature low byte read-only, default zero, writes ignored.
// R7 - Per-channel signature high byte read-only at next location, default zero.
// R8 - Per-channel 4-bit fine sampling delay, 0.075 ps steps, up to 1.125 ps.
// R9 - Shadowed program register writes act only when transfer is requested, all together.
// R10 - Writing 0x01 to transfer register updates shadows; the bit clears itself.
// R11 - Channel bits route local writes to one or both; both-set read returns channel one.
// R12 - Power-down field: 00 run, 01 full power-down, other codes reserved.
// R13 - Nonzero test-mode code replaces channel output with the chosen test pattern.
//
// Purpose: Register offsets, field positions and reset values of the config bank.
// Assumes: 8-bit address, 8-bit data, one access per cycle.
// Notes:   Definitions only.
`ifndef ACRB_CONSTS_VH
`define ACRB_CONSTS_VH
`define ACRB_A_INDEX     8'h05
`define ACRB_A_XFER      8'hFF
`define ACRB_A_POWER     8'h08
`define ACRB_A_CLOCK     8'h09
`define ACRB_A_TEST      8'h0D
`define ACRB_A_SELFTEST  8'h0E
`define ACRB_A_INPUT     8'h0F
`define ACRB_A_OFFSET    8'h10
`define ACRB_A_OUTFMT    8'h14
`define ACRB_A_OUTPHASE  8'h16
`define ACRB_A_REFSCALE  8'h18
`define ACRB_A_SIG_LO    8'h24
`define ACRB_A_SIG_HI    8'h25
`define ACRB_A_FINE      8'h37
`define ACRB_A_COARSE    8'h38
`define ACRB_R_INDEX     8'hFF
`define ACRB_R_XFER      8'hFF
`define ACRB_R_POWER     8'h00
`define ACRB_R_CLOCK     8'h09
`define ACRB_R_TEST      8'h00
`define ACRB_R_SELFTEST  8'h00
`define ACRB_R_INPUT     8'h02
`define ACRB_R_OFFSET    8'h00
`define ACRB_R_OUTFMT    8'h00
`define ACRB_R_OUTPHASE  8'h00
`define ACRB_R_REFSCALE  8'h00
`define ACRB_R_FINE      8'h00
`define ACRB_R_COARSE    8'h00
`define ACRB_XFER_CMD    8'h01
`define ACRB_XFER_IDLE   8'h00
`define ACRB_B_SMODE     4
`define ACRB_B_BOOST     1
`define ACRB_B_DCS       0
`define ACRB_B_OUTEN     6
`define ACRB_B_INVERT    2
`define ACRB_B_DISC      2
`define ACRB_B_CMEN      1
`define ACRB_B_STINIT    2
`define ACRB_B_STEN      0
`define ACRB_B_DCOINV    7
`define ACRB_PD_RUN      2'h0
`define ACRB_PD_FULL     2'h1
`define ACRB_FMT_OBIN    2'h0
`define ACRB_FMT_TWOS    2'h1
`define ACRB_FMT_GRAY    2'h2
`define ACRB_TM_OFF      3'h0
`define ACRB_TM_MID      3'h1
`define ACRB_TM_PFS      3'h2
`define ACRB_TM_NFS      3'h3
`define ACRB_TM_CHECK    3'h4
`define ACRB_TM_PN23     3'h5
`define ACRB_TM_PN9      3'h6
`define ACRB_TM_TOGGLE   3'h7
`endif

/* File: acrb_bank_chk_asserts.sv */
// Purpose: Concurrent checks on the ports of the config register bank.
// Assumes: The host leaves one idle cycle between two accesses.
// Notes:   Shadowed outputs may only move on the edge after a transfer request.
`timescale 1ns/10ps
`default_nettype none
module acrb_bank_chk #(
  parameter DW = 8
) (
  // Clock and reset.
  input wire logic          sys_clk,
  input wire logic          rst_n,
  // Register access.
  input wire logic          wr_en,
  input wire logic          rd_en,
  input wire logic [7:0]    addr,
  input wire logic [7:0]    wdata,
  input wire logic [7:0]    rdata_q,
  // Active configuration and data.
  input wire logic          power_down,
  input wire logic          simultaneous,
  input wire logic [4:0]    ref_scale,
  input wire logic [7:0]    fine_skew,
  input wire logic [7:0]    coarse_skew,
  input wire logic [1:0]    out_en,
  input wire logic [DW-1:0] dout_ch1_q
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A transfer request as seen on the strobes.
  wire logic xfer;
  assign xfer = wr_en && addr == 8'hFF && wdata == 8'h01;
  AST_SHADOW_HOLD: assert property (!xfer |=>
    $stable({power_down, simultaneous, ref_scale, fine_skew, coarse_skew, out_en})) else $error("config moved early");
  AST_SMODE: assert property (wr_en && addr == 8'h09 ##2 xfer |=> simultaneous == $past(wdata[4], 3))
    else $error("sample mode wrong");
  AST_POWER: assert property (wr_en && addr == 8'h08 ##2 xfer |=> power_down == ($past(wdata[1:0], 3) == 2'h1))
    else $error("power mode wrong");
  AST_REF: assert property (wr_en && addr == 8'h18 ##2 xfer |=> ref_scale == $past(wdata[4:0], 3))
    else $error("reference scale wrong");
  AST_COARSE: assert property (wr_en && addr == 8'h38 ##2 xfer |=> coarse_skew == $past(wdata, 3))
    else $error("coarse skew wrong");
  AST_XFER_CLR: assert property (wr_en && addr == 8'hFF ##2 rd_en && addr == 8'hFF |=> rdata_q == 8'h00)
    else $error("transfer bit not cleared");
  AST_FINE_BOTH: assert property (wr_en && addr == 8'h05 && wdata[1:0] == 2'h3 ##2 wr_en && addr == 8'h37
    ##2 xfer |=> fine_skew == {2{$past(wdata[3:0], 3)}}) else $error("fine skew not shared");
  AST_OUT_OFF: assert property (!out_en[0] && !$past(out_en[0]) |-> dout_ch1_q == '0)
    else $error("disabled output not quiet");
  // Main scenarios reached.
  cover property (xfer);
  cover property ($rose(power_down));
  cover property (rd_en && addr == 8'h25);
endmodule // acrb_bank_chk
bind acrb_bank acrb_bank_chk #(.DW(DW)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
  .addr(addr), .wdata(wdata), .rdata_q(rdata_q), .power_down(power_down), .simultaneous(simultaneous),
  .ref_scale(ref_scale), .fine_skew(fine_skew), .coarse_skew(coarse_skew), .out_en(out_en), .dout_ch1_q(dout_ch1_q));
`default_nettype wire

/* File: acrb_host_model.sv */
// Purpose: Host side of the register port, issuing strobed reads and writes.
// Assumes: Called just after a clock edge or at the start of a test.
// Notes:   Released address and data show the inverse so stale values never match.
`timescale 1ns/10ps
`default_nettype none
module acrb_host_model (
  // Clock.
  input  wire logic       sys_clk,
  // Strobes towards the bank.
  output var  logic       wr_en,
  output var  logic       rd_en,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata,
  // Read data from the bank.
  input  wire logic [7:0] rdata_q
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus at time zero.
  initial begin
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    addr  <= 8'h00;
    wdata <= 8'h00;
  end
  // One write; a transfer is a write of 0x01 to 0xFF.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
    // Let the edge that took the write settle, so callers never see pre-edge outputs.
    #1;
  endtask
  // One read; data is taken the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    addr  <= ~a;
    #1;
    d = rdata_q;
  endtask
endmodule // acrb_host_model
`default_nettype wire

/* File: acrb_bank_tb_top.sv */
// Purpose: Self-checking bench for the config register bank.
// Assumes: Host model drives the strobes; bench drives signatures and raw data.
// Notes:   Expected values come from the register map and format rules.
`timescale 1ns/10ps
`default_nettype none
module acrb_bank_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sig_load = 1'b0;
  logic [15:0] sig_ch1 = 16'h0000;
  logic [15:0] sig_ch2 = 16'h0000;
  logic [7:0]  raw_ch1 = 8'h9C;
  logic [7:0]  raw_ch2 = 8'h9C;
  wire logic   wr_en, rd_en, power_down, simultaneous;
  wire logic [7:0] addr, wdata, rdata_q, fine_skew, coarse_skew, dout_ch1_q, dout_ch2_q;
  wire logic [4:0] ref_scale;
  wire logic [1:0] out_en, disconnect, selftest_en, selftest_init;
  wire logic   clock_boost, duty_stab, cm_input_en, dco_invert;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [7:0]  rv;
  // Reset values per address, then one unmapped address.
  logic [15:0] dflt [0:15] = '{16'h05FF, 16'hFFFF, 16'h0800, 16'h0909, 16'h0D00, 16'h0E00, 16'h0F02, 16'h1000,
                               16'h1400, 16'h1600, 16'h1800, 16'h2400, 16'h2500, 16'h3700, 16'h3800, 16'h4000};
  // Test code, offset, output mode, expected data for raw 0x9C; the last row is the reserved format.
  logic [31:0] dtab [0:9] = '{32'h0000409C, 32'h0000411C, 32'h000042D2, 32'h00004463, 32'h000740A3,
                              32'h00084094, 32'h01004080, 32'h020040FF, 32'h03004000, 32'h0000439C};
  // ----------------------------------------------------------------
  // Structure and clock
  // ----------------------------------------------------------------
  always #12.5 sys_clk = ~sys_clk;
  acrb_host_model host (.sys_clk(sys_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata_q(rdata_q));
  acrb_bank #(.DW(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata_q(rdata_q), .sig_ch1(sig_ch1), .sig_ch2(sig_ch2), .sig_load(sig_load), .raw_ch1(raw_ch1),
    .raw_ch2(raw_ch2), .power_down(power_down), .simultaneous(simultaneous), .clock_boost(clock_boost),
    .duty_stab(duty_stab), .cm_input_en(cm_input_en), .dco_invert(dco_invert), .ref_scale(ref_scale),
    .disconnect(disconnect), .selftest_en(selftest_en), .selftest_init(selftest_init),
    .fine_skew(fine_skew), .coarse_skew(coarse_skew), .out_en(out_en), .dout_ch1_q(dout_ch1_q), .dout_ch2_q(dout_ch2_q));
  // ----------------------------------------------------------------
  // Helpers and scenarios
  // ----------------------------------------------------------------
  task automatic final_report;
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic xfer;
    host.wr(8'hFF, 8'h01);
  endtask
  // Reset values of every register and the quiet outputs.
  task automatic t_defaults;
    foreach (dflt[i]) rdchk(dflt[i][15:8], dflt[i][7:0]);
    chk({7'h00, simultaneous}, 8'h00);
    chk(dout_ch1_q, 8'h00);
    chk({4'h0, clock_boost, duty_stab, cm_input_en, dco_invert}, 8'h06);
    chk({2'h0, disconnect, selftest_en, selftest_init}, 8'h00);
  endtask
  // Shadowed writes wait for a proper transfer, then land together.
  task automatic t_shadow;
    host.wr(8'h09, 8'h1B);
    chk({7'h00, simultaneous}, 8'h00);
    rdchk(8'h09, 8'h1B);
    host.wr(8'hFF, 8'h02);
    rdchk(8'hFF, 8'h00);
    chk({7'h00, simultaneous}, 8'h00);
    host.wr(8'h16, 8'h80);
    host.wr(8'h0F, 8'h04);
    host.wr(8'h0E, 8'h05);
    host.wr(8'h18, 8'h13);
    xfer();
    chk({7'h00, simultaneous}, 8'h01);
    chk({3'h0, ref_scale}, 8'h13);
    chk({4'h0, clock_boost, duty_stab, cm_input_en, dco_invert}, 8'h0D);
    chk({2'h0, disconnect, selftest_en, selftest_init}, 8'h3F);
    host.wr(8'h38, 8'h0A);
    xfer();
    chk(coarse_skew, 8'h0A);
    host.wr(8'h09, 8'h09);
    xfer();
    chk({7'h00, simultaneous}, 8'h00);
  endtask
  // Every power code; only 01 powers down.
  task automatic t_power;
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h08, 8'(c));
      xfer();
      chk({7'h00, power_down}, {7'h00, c == 1});
    end
  endtask
  // Signatures and fine skew steered by the channel index.
  task automatic t_channel;
    @(posedge sys_clk);
    sig_ch1 <= 16'hA55A;
    sig_ch2 <= 16'h1234;
    sig_load <= 1'b1;
    @(posedge sys_clk);
    sig_load <= 1'b0;
    host.wr(8'h05, 8'h01);
    host.wr(8'h24, 8'hFF);
    rdchk(8'h24, 8'h5A);
    rdchk(8'h25, 8'hA5);
    host.wr(8'h05, 8'h02);
    rdchk(8'h25, 8'h12);
    host.wr(8'h05, 8'h03);
    host.wr(8'h37, 8'h06);
    xfer();
    chk(fine_skew, 8'h66);
    host.wr(8'h05, 8'h01);
    host.wr(8'h37, 8'h05);
    host.wr(8'h05, 8'h02);
    host.wr(8'h37, 8'h0F);
    xfer();
    chk(fine_skew, 8'hF5);
    host.wr(8'h05, 8'h03);
    rdchk(8'h37, 8'h05);
  endtask
  // Output formats, inversion, offset trim and test patterns on both channels.
  task automatic t_data;
    foreach (dtab[i]) begin
      host.wr(8'h0D, dtab[i][31:24]);
      host.wr(8'h10, dtab[i][23:16]);
      host.wr(8'h14, dtab[i][15:8]);
      xfer();
      repeat (2) @(posedge sys_clk);
      #1;
      chk(dout_ch1_q, dtab[i][7:0]);
      chk(dout_ch2_q, dtab[i][7:0]);
    end
  endtask
  // Checkerboard and word toggle: the phase is free, so judge two samples in a row.
  task automatic t_pattern;
    logic [7:0] a;
    for (int m = 4; m < 8; m += 3) begin
      host.wr(8'h0D, 8'(m));
      xfer();
      repeat (2) @(posedge sys_clk);
      #1;
      a = dout_ch1_q;
      @(posedge sys_clk);
      #1;
      chk(a ^ dout_ch1_q, 8'hFF);
      chk({7'h00, (m == 4) ? (a == 8'h55 || a == 8'hAA) : (a == 8'h00 || a == 8'hFF)}, 8'h01);
    end
  endtask
  // Main sequence; a hang is cut short by the cycle ceiling.
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_defaults();
    t_shadow();
    t_power();
    t_channel();
    t_data();
    t_pattern();
    final_report();
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
endmodule // acrb_bank_tb_top
`default_nettype wire
